// *** common/wid_regs.svh ***
// Purpose: Offsets, field positions, vectors and reset values of the wake/interrupt dispatch
// Assumes: Byte-wide register port with a 4-bit word address
// Notes:   Definitions only
`ifndef WID_REGS_SVH
`define WID_REGS_SVH

// Register port widths and source count
`define WID_ADDR_W        4
`define WID_DATA_W        8
`define WID_SRC_COUNT     6

// Register offsets
`define WID_OFS_CTRL      4'h0
`define WID_OFS_MASK      4'h1
`define WID_OFS_FLAG      4'h2
`define WID_OFS_STATUS    4'h3

// Control fields
`define WID_CTRL_CMP_WAKE 0
`define WID_CTRL_WDT_ON   1

// Source positions in mask and flag registers
`define WID_SRC_CMP       0
`define WID_SRC_HP        1
`define WID_SRC_LP        2
`define WID_SRC_AUX1      3
`define WID_SRC_AUX2      4
`define WID_SRC_AUX3      5
`define WID_AUX_COUNT     3

// Status fields
`define WID_STAT_SLEEP    0
`define WID_STAT_GIE      1
`define WID_STAT_CLK_STOP 2

// Program addresses
`define WID_VEC_CMP       8'h0F
`define WID_VEC_HP        8'h12
`define WID_VEC_LP        8'h15
`define WID_VEC_AUX1      8'h18
`define WID_VEC_AUX2      8'h1B
`define WID_VEC_AUX3      8'h1E
`define WID_VEC_RESET     8'h00

// Reset values
`define WID_MASK_RST      6'h00
`define WID_FLAG_RST      6'h00

`endif

// *** common/wid_pkg.sv ***
// Purpose: Types of the wake/interrupt dispatch
// Assumes: wid_regs.svh supplies widths
// Notes:   State structs are registered whole
`include "wid_regs.svh"

package wid_pkg;

   // Dispatcher modes
   typedef enum logic [1:0] {
      WID_NORMAL,
      WID_SLEEP,
      WID_WDT_WAKE
   } wid_state_t;

   // Main dispatcher state
   typedef struct packed {
      wid_state_t                 state;
      logic                       gie;
      logic                       cmp_wake_en;
      logic                       watchdog_on;
      logic [`WID_SRC_COUNT-1:0]  mask;
      logic [`WID_DATA_W-1:0]     rdata;
      logic                       wake;
      logic                       vec_req;
      logic [`WID_DATA_W-1:0]     vec_addr;
      logic                       rst_req;
   } wid_core_st_t;

   // Flag bank state
   typedef struct packed {
      logic [`WID_SRC_COUNT-1:0]  flags;
   } wid_flag_st_t;

endpackage : wid_pkg

// *** verilog/wid_flag_bank.sv ***
// Purpose: Sticky source flags, set by events, cleared by software
// Assumes: Set and clear are one-cycle pulses
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "wid_regs.svh"

module wid_flag_bank (
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_resetn,
   // Flag control
   input  wire logic [`WID_SRC_COUNT-1:0] i_set,
   input  wire logic [`WID_SRC_COUNT-1:0] i_clr,
   output logic      [`WID_SRC_COUNT-1:0] o_flags
);

   wid_pkg::wid_flag_st_t r;
   wid_pkg::wid_flag_st_t n;

   // Hold until cleared, set has priority
   always_comb begin
      n = r;
      n.flags = (r.flags & ~i_clr) | i_set;
   end

   // State register
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         r.flags <= `WID_FLAG_RST;
      end else begin
         r <= n;
      end
   end

   assign o_flags = r.flags;

endmodule : wid_flag_bank
`default_nettype wire

// *** verilog/wid_vector_select.sv ***
// Purpose: Pick the pending source with the lowest vector
// Assumes: Pending bits are already masked
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "wid_regs.svh"

module wid_vector_select (
   // Pending sources
   input  wire logic [`WID_SRC_COUNT-1:0] i_pending,
   // Selection
   output logic                           o_any,
   output logic      [`WID_DATA_W-1:0]    o_addr
);

   // Vector of one source position
   function automatic logic [`WID_DATA_W-1:0] vec_of(input int idx);
      case (idx)
         `WID_SRC_CMP:  vec_of = `WID_VEC_CMP;
         `WID_SRC_HP:   vec_of = `WID_VEC_HP;
         `WID_SRC_LP:   vec_of = `WID_VEC_LP;
         `WID_SRC_AUX1: vec_of = `WID_VEC_AUX1;
         `WID_SRC_AUX2: vec_of = `WID_VEC_AUX2;
         default:       vec_of = `WID_VEC_AUX3;
      endcase
   endfunction : vec_of

   // Lowest position wins
   always_comb begin
      o_addr = `WID_VEC_RESET;
      for (int i = `WID_SRC_COUNT - 1; i >= 0; i--) begin
         if (i_pending[i]) begin
            o_addr = vec_of(i);
         end
      end
   end

   assign o_any = |i_pending;

endmodule : wid_vector_select
`default_nettype wire

// *** verilog/wid_dispatch.sv ***
// Purpose: Wake-up and interrupt dispatch for comparator, pulse-width, aux timer, watchdog
// Assumes: Core pulses sleep and global enable ops; source events are one-cycle pulses
// Notes:   Registers on a byte port, read data one cycle after the read strobe
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "wid_regs.svh"

module wid_dispatch (
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_resetn,
   // Register port
   input  wire logic [`WID_ADDR_W-1:0]    i_addr,
   input  wire logic [`WID_DATA_W-1:0]    i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic      [`WID_DATA_W-1:0]    o_rdata,
   // Core sequencer
   input  wire logic                      i_sleep_cmd,
   input  wire logic                      i_global_int_on_op,
   input  wire logic                      i_global_int_off_op,
   output logic                           o_wake,
   output logic                           o_vector_req,
   output logic      [`WID_DATA_W-1:0]    o_vector_addr,
   output logic                           o_reset_req,
   output logic                           o_clocks_stopped,
   output logic                           o_sleeping,
   output logic                           o_global_int,
   // Event sources
   input  wire logic                      i_cmp_change,
   input  wire logic                      i_high_pulse_underflow,
   input  wire logic                      i_low_pulse_underflow,
   input  wire logic [`WID_AUX_COUNT-1:0] i_aux_timer_ovf,
   input  wire logic                      i_watchdog_timeout
);

   wid_pkg::wid_core_st_t r;
   wid_pkg::wid_core_st_t n;

   logic                      sleep_now;
   logic                      awake;
   logic                      wdt_fire;
   logic [`WID_SRC_COUNT-1:0] flag_set;
   logic [`WID_SRC_COUNT-1:0] flag_clr;
   logic [`WID_SRC_COUNT-1:0] flags;
   logic [`WID_SRC_COUNT-1:0] pending;
   logic                      any_pending;
   logic [`WID_DATA_W-1:0]    sel_addr;

   // Mode decode
   assign sleep_now = (r.state == wid_pkg::WID_SLEEP);
   assign awake     = (r.state == wid_pkg::WID_NORMAL);
   assign wdt_fire  = r.watchdog_on & i_watchdog_timeout;

   // Flag setting per source
   assign flag_set[`WID_SRC_CMP] = i_cmp_change & r.mask[`WID_SRC_CMP]
                                   & (sleep_now | awake);
   assign flag_set[`WID_SRC_HP]  = i_high_pulse_underflow & r.mask[`WID_SRC_HP]
                                   & awake;
   assign flag_set[`WID_SRC_LP]  = i_low_pulse_underflow & r.mask[`WID_SRC_LP]
                                   & awake;
   assign flag_set[`WID_SRC_AUX1 +: `WID_AUX_COUNT] =
          i_aux_timer_ovf & r.mask[`WID_SRC_AUX1 +: `WID_AUX_COUNT]
          & {`WID_AUX_COUNT{awake}};

   // Write one to clear
   assign flag_clr = (i_wr && (i_addr == `WID_OFS_FLAG)) ?
                     i_wdata[`WID_SRC_COUNT-1:0] : `WID_FLAG_RST;

   // Sticky flags
   wid_flag_bank u_flags (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_set    (flag_set),
      .i_clr    (flag_clr),
      .o_flags  (flags)
   );

   assign pending = flags & r.mask;

   // Vector choice
   wid_vector_select u_select (
      .i_pending (pending),
      .o_any     (any_pending),
      .o_addr    (sel_addr)
   );

   // Next state
   always_comb begin
      n = r;
      n.wake    = 1'b0;
      n.vec_req = 1'b0;
      n.rst_req = 1'b0;
      n.rdata   = '0;

      // Global enable ops
      if (i_global_int_on_op) begin
         n.gie = 1'b1;
      end else if (i_global_int_off_op) begin
         n.gie = 1'b0;
      end

      // Register writes
      if (i_wr) begin
         if (i_addr == `WID_OFS_CTRL) begin
            n.cmp_wake_en = i_wdata[`WID_CTRL_CMP_WAKE];
            n.watchdog_on = i_wdata[`WID_CTRL_WDT_ON];
         end else if (i_addr == `WID_OFS_MASK) begin
            n.mask = i_wdata[`WID_SRC_COUNT-1:0];
         end
      end

      // Register reads, unmapped reads give zero
      if (i_rd) begin
         if (i_addr == `WID_OFS_CTRL) begin
            n.rdata[`WID_CTRL_CMP_WAKE] = r.cmp_wake_en;
            n.rdata[`WID_CTRL_WDT_ON]   = r.watchdog_on;
         end else if (i_addr == `WID_OFS_MASK) begin
            n.rdata[`WID_SRC_COUNT-1:0] = r.mask;
         end else if (i_addr == `WID_OFS_FLAG) begin
            n.rdata[`WID_SRC_COUNT-1:0] = flags;
         end else if (i_addr == `WID_OFS_STATUS) begin
            n.rdata[`WID_STAT_SLEEP]    = sleep_now;
            n.rdata[`WID_STAT_GIE]      = r.gie;
            n.rdata[`WID_STAT_CLK_STOP] = sleep_now;
         end
      end

      // Mode sequencing
      case (r.state)
         wid_pkg::WID_NORMAL: begin
            if (wdt_fire) begin
               n.rst_req  = 1'b1;
               n.vec_addr = `WID_VEC_RESET;
               n.gie      = 1'b0;
            end else if (r.gie && any_pending && !r.vec_req) begin
               n.vec_req  = 1'b1;
               n.vec_addr = sel_addr;
               n.gie      = 1'b0;
            end else if (i_sleep_cmd) begin
               n.state = wid_pkg::WID_SLEEP;
            end
         end
         wid_pkg::WID_SLEEP: begin
            if (wdt_fire) begin
               n.wake  = 1'b1;
               n.state = wid_pkg::WID_WDT_WAKE;
            end else if (i_cmp_change && r.cmp_wake_en) begin
               n.wake  = 1'b1;
               n.state = wid_pkg::WID_NORMAL;
            end
         end
         wid_pkg::WID_WDT_WAKE: begin
            n.rst_req  = 1'b1;
            n.vec_addr = `WID_VEC_RESET;
            n.gie      = 1'b0;
            n.state    = wid_pkg::WID_NORMAL;
         end
         default: begin
            n.state = wid_pkg::WID_NORMAL;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         r.state       <= wid_pkg::WID_NORMAL;
         r.gie         <= 1'b0;
         r.cmp_wake_en <= 1'b0;
         r.watchdog_on <= 1'b0;
         r.mask        <= `WID_MASK_RST;
         r.rdata       <= '0;
         r.wake        <= 1'b0;
         r.vec_req     <= 1'b0;
         r.vec_addr    <= `WID_VEC_RESET;
         r.rst_req     <= 1'b0;
      end else begin
         r <= n;
      end
   end

   // Outputs
   assign o_rdata          = r.rdata;
   assign o_wake           = r.wake;
   assign o_vector_req     = r.vec_req;
   assign o_vector_addr    = r.vec_addr;
   assign o_reset_req      = r.rst_req;
   assign o_clocks_stopped = (r.state == wid_pkg::WID_SLEEP);
   assign o_sleeping       = (r.state == wid_pkg::WID_SLEEP);
   assign o_global_int     = r.gie;

   // Quiet comparator in sleep
   chk_cmp_quiet: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && i_cmp_change && !r.cmp_wake_en && !r.mask[`WID_SRC_CMP]
       && !wdt_fire)
      |=> !o_wake && o_sleeping && !(flags[`WID_SRC_CMP] && !$past(flags[`WID_SRC_CMP])))
      else $error("comparator acted with wake and enable off");

   chk_cmp_flag_only: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && i_cmp_change && !r.cmp_wake_en && r.mask[`WID_SRC_CMP]
       && !wdt_fire)
      |=> flags[`WID_SRC_CMP] && !o_wake && o_sleeping)
      else $error("comparator flag-only case wrong");

   chk_cmp_wake: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && i_cmp_change && r.cmp_wake_en && !r.mask[`WID_SRC_CMP]
       && !wdt_fire)
      |=> o_wake && !o_sleeping && !o_vector_req)
      else $error("comparator wake without flag wrong");

   chk_cmp_wake_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && i_cmp_change && r.cmp_wake_en && r.mask[`WID_SRC_CMP]
       && !wdt_fire)
      |=> o_wake && flags[`WID_SRC_CMP] && !o_clocks_stopped)
      else $error("comparator wake with flag wrong");

   chk_cmp_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_cmp_change && r.mask[`WID_SRC_CMP] && r.gie && !i_global_int_off_op
       && !wdt_fire && !r.vec_req && (pending == `WID_FLAG_RST)
       && (awake || (sleep_now && r.cmp_wake_en)))
      |-> ##[1:3] (o_vector_req && (o_vector_addr == `WID_VEC_CMP)))
      else $error("comparator vector not taken");

   chk_sleep_clocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && i_sleep_cmd && !wdt_fire && !(r.gie && any_pending) && !r.vec_req)
      |=> o_clocks_stopped && o_sleeping)
      else $error("clocks not stopped in sleep");

   chk_norm_no_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && i_cmp_change && !r.mask[`WID_SRC_CMP])
      |=> !(flags[`WID_SRC_CMP] && !$past(flags[`WID_SRC_CMP])))
      else $error("comparator flag set while disabled");

   chk_timer_no_wake: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && !i_cmp_change && !wdt_fire)
      |=> !o_wake && o_sleeping)
      else $error("timer event woke the device");

   chk_aux_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && (flag_set[`WID_SRC_AUX1 +: `WID_AUX_COUNT] != '0))
      |=> ((flags[`WID_SRC_AUX1 +: `WID_AUX_COUNT]
            & $past(flag_set[`WID_SRC_AUX1 +: `WID_AUX_COUNT]))
           == $past(flag_set[`WID_SRC_AUX1 +: `WID_AUX_COUNT])))
      else $error("aux timer flag not set");

   chk_vec_gated: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_vector_req |-> $past(r.gie) && !o_global_int)
      else $error("vector without global enable");

   chk_wdt_reset: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (sleep_now && wdt_fire)
      |=> o_wake ##1 (o_reset_req && (o_vector_addr == `WID_VEC_RESET)))
      else $error("watchdog sleep reset sequence wrong");

   // Watchdog in normal mode, and while switched off
   chk_wdt_normal: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && wdt_fire)
      |=> o_reset_req && !o_vector_req && (o_vector_addr == `WID_VEC_RESET)
          && !o_global_int)
      else $error("watchdog reset in normal mode wrong");

   chk_wdt_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && i_watchdog_timeout && !r.watchdog_on)
      |=> !o_reset_req && !o_wake)
      else $error("watchdog acted while switched off");

   // Fixed vector per timer source, lower vectors idle
   chk_hp_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && r.gie && !r.vec_req && !wdt_fire && pending[`WID_SRC_HP]
       && !pending[`WID_SRC_CMP])
      |=> o_vector_req && (o_vector_addr == `WID_VEC_HP))
      else $error("high pulse vector wrong");

   chk_lp_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && r.gie && !r.vec_req && !wdt_fire && pending[`WID_SRC_LP]
       && (pending[`WID_SRC_HP:`WID_SRC_CMP] == '0))
      |=> o_vector_req && (o_vector_addr == `WID_VEC_LP))
      else $error("low pulse vector wrong");

   chk_aux1_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && r.gie && !r.vec_req && !wdt_fire && pending[`WID_SRC_AUX1]
       && (pending[`WID_SRC_LP:`WID_SRC_CMP] == '0))
      |=> o_vector_req && (o_vector_addr == `WID_VEC_AUX1))
      else $error("aux timer 1 vector wrong");

   chk_aux2_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && r.gie && !r.vec_req && !wdt_fire && pending[`WID_SRC_AUX2]
       && (pending[`WID_SRC_AUX1:`WID_SRC_CMP] == '0))
      |=> o_vector_req && (o_vector_addr == `WID_VEC_AUX2))
      else $error("aux timer 2 vector wrong");

   chk_aux3_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (awake && r.gie && !r.vec_req && !wdt_fire && pending[`WID_SRC_AUX3]
       && (pending[`WID_SRC_AUX2:`WID_SRC_CMP] == '0))
      |=> o_vector_req && (o_vector_addr == `WID_VEC_AUX3))
      else $error("aux timer 3 vector wrong");

endmodule : wid_dispatch
`default_nettype wire

// *** tb/wid_core_model.sv ***
// Purpose: Behavioural core sequencer facing the dispatcher
// Assumes: Bench requests are one-cycle pulses
// Notes:   Tracks the program counter across branches and resets
`timescale 1ns/1ns
`default_nettype none

module wid_core_model #(
   parameter logic [7:0] IDLE_PC = 8'h80
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   // Bench requests: bit2 sleep, bit1 global off, bit0 global on
   input  wire logic [2:0] i_req,
   // Dispatcher answers
   input  wire logic       i_vector_req,
   input  wire logic [7:0] i_vector_addr,
   input  wire logic       i_reset_req,
   // Core operations
   output logic            o_sleep_cmd,
   output logic            o_global_int_on_op,
   output logic            o_global_int_off_op,
   output logic [7:0]      o_pc
);
   // Ops leave one cycle after the request, as an executed instruction would
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         {o_sleep_cmd, o_global_int_off_op, o_global_int_on_op} <= 3'b000;
         o_pc <= IDLE_PC;
      end else begin
         {o_sleep_cmd, o_global_int_off_op, o_global_int_on_op} <= i_req;
         if (i_reset_req) begin
            o_pc <= 8'h00;
         end else if (i_vector_req) begin
            o_pc <= i_vector_addr;
         end
      end
   end
endmodule : wid_core_model
`default_nettype wire

// *** tb/wakeup_interrupt_dispatch_tb.sv ***
// Purpose: Self-checking bench of the wake/interrupt dispatch
// Assumes: Core model issues sleep and global enable ops
// Notes:   Each trial starts from reset; random trials use a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "wid_regs.svh"

module wakeup_interrupt_dispatch_tb;
   localparam logic [7:0] IDLE_PC = 8'h80;
   localparam logic [7:0] VEC_TAB [0:5] = '{8'h0F, 8'h12, 8'h15, 8'h18, 8'h1B, 8'h1E};
   // Bench signals
   logic                   i_clock   = 1'b0;
   logic                   i_resetn  = 1'b0;
   logic [`WID_ADDR_W-1:0] addr      = '0;
   logic [7:0]             wdata     = '0;
   logic                   wr        = 1'b0;
   logic                   rd        = 1'b0;
   logic [2:0]             req       = '0;
   logic [6:0]             ev        = '0;
   logic [7:0]             rdata, vaddr, pc;
   logic                   sleep_cmd, on_op, off_op, wake, vreq, rreq, stopped, sleeping, gint;
   int                     failures  = 0;
   int                     cmp_count = 0;

   wid_dispatch u_wid_dispatch (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sleep_cmd(sleep_cmd),
      .i_global_int_on_op(on_op), .i_global_int_off_op(off_op), .o_wake(wake),
      .o_vector_req(vreq), .o_vector_addr(vaddr), .o_reset_req(rreq),
      .o_clocks_stopped(stopped), .o_sleeping(sleeping), .o_global_int(gint),
      .i_cmp_change(ev[0]), .i_high_pulse_underflow(ev[1]), .i_low_pulse_underflow(ev[2]),
      .i_aux_timer_ovf(ev[5:3]), .i_watchdog_timeout(ev[6]));

   wid_core_model #(.IDLE_PC(IDLE_PC)) u_wid_core_model (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_req(req), .i_vector_req(vreq),
      .i_vector_addr(vaddr), .i_reset_req(rreq), .o_sleep_cmd(sleep_cmd),
      .o_global_int_on_op(on_op), .o_global_int_off_op(off_op), .o_pc(pc));

   // 250 MHz clock
   initial begin
      forever #2 i_clock = ~i_clock;
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge i_clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   task automatic core_op(input int b);
      @(posedge i_clock);
      req[b] <= 1'b1;
      @(posedge i_clock);
      req <= '0;
   endtask : core_op

   // Counts wake, vector and reset pulses over six cycles
   task automatic watch(output logic [7:0] nw, output logic [7:0] nv, output logic [7:0] nr);
      nw = 0;
      nv = 0;
      nr = 0;
      // Called at a launch edge, so the first look sees a one-cycle pulse
      repeat (6) begin
         #1;
         nw += 8'(wake);
         nv += 8'(vreq);
         nr += 8'(rreq);
         @(posedge i_clock);
      end
      #1;
   endtask : watch

   // Expected {wake, flag, vector, reset} for one source event
   function automatic logic [3:0] expect_of(int src, bit sl, bit we, bit ie, bit g, bit wd);
      if (src == 6) begin
         return {sl & wd, 1'b0, 1'b0, wd};
      end else if (src == 0) begin
         return {sl & we, ie, ie & g & (we | ~sl), 1'b0};
      end
      return {1'b0, ie & ~sl, ie & g & ~sl, 1'b0};
   endfunction : expect_of

   task automatic trial(input int src, input bit sl, we, ie, g_on, g_off, wd);
      logic [3:0] e;
      logic [5:0] m;
      logic [7:0] r, nw, nv, nr;
      bit         g;
      g = g_on & ~g_off;
      e = expect_of(src, sl, we, ie, g, wd);
      m = 6'($urandom);
      if (src < 6) begin
         m[src] = ie;
      end
      @(posedge i_clock);
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      bus_wr(`WID_OFS_CTRL, {6'h00, wd, we});
      bus_wr(`WID_OFS_MASK, {2'b00, m});
      if (g_on) core_op(0);
      if (g_off) core_op(1);
      if (sl) core_op(2);
      repeat (2) @(posedge i_clock);
      #1;
      check(stopped, sl);
      check(gint, g);
      bus_rd(`WID_OFS_STATUS, r);
      check(r, {5'h00, sl, g, sl});
      @(posedge i_clock);
      ev <= 7'(1) << src;
      @(posedge i_clock);
      ev <= '0;
      watch(nw, nv, nr);
      check(nw, e[3]);
      check(nv, e[1]);
      check(nr, e[0]);
      check(pc, e[0] ? 8'h00 : e[1] ? VEC_TAB[src] : IDLE_PC);
      check(sleeping, sl & ~e[3]);
      check(stopped, sl & ~e[3]);
      check(gint, g & ~e[1] & ~e[0]);
      bus_rd(`WID_OFS_FLAG, r);
      check(r, {2'b00, 6'(e[2]) << src});
      if (e[1]) begin
         // Flag left set re-vectors; cleared flag does not
         core_op(0);
         watch(nw, nv, nr);
         check(nv, 8'd1);
         bus_wr(`WID_OFS_FLAG, 8'hFF);
         core_op(0);
         watch(nw, nv, nr);
         check(nv, 8'd0);
         bus_rd(`WID_OFS_FLAG, r);
         check(r, 8'h00);
      end
   endtask : trial

   // Hang guard, well beyond the expected run length
   initial begin
      #(4 * 40000);
      failures++;
      complete_run();
   end

   // Main sequence
   initial begin
      logic [7:0] r, d;
      void'($urandom(32'h9993));
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      // Register map, unmapped and read-only places
      bus_rd(`WID_OFS_STATUS, r);
      check(r, 8'h00);
      d = 8'($urandom);
      bus_wr(`WID_OFS_MASK, d);
      bus_rd(`WID_OFS_MASK, r);
      check(r, {2'b00, d[5:0]});
      bus_wr(`WID_OFS_CTRL, d);
      bus_rd(`WID_OFS_CTRL, r);
      check(r, {6'h00, d[1:0]});
      @(posedge i_clock);
      #1;
      check(rdata, 8'h00);
      bus_wr(`WID_OFS_STATUS, 8'hFF);
      bus_rd(`WID_OFS_STATUS, r);
      check(r, 8'h00);
      for (int a = 4; a < 16; a++) begin
         bus_wr(4'(a), 8'($urandom));
         bus_rd(4'(a), r);
         check(r, 8'h00);
      end
      // Every comparator configuration, asleep and awake
      for (int i = 0; i < 16; i++) begin
         trial(0, i[3], i[2], i[1], i[0], 1'b0, 1'b0);
      end
      // Other sources and the watchdog in both modes
      for (int s = 1; s < 7; s++) begin
         trial(s, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
         trial(s, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      end
      repeat (60) begin
         trial($urandom_range(6), 1'($urandom), 1'($urandom), 1'($urandom),
               1'($urandom), 1'($urandom), 1'($urandom));
      end
      complete_run();
   end
endmodule : wakeup_interrupt_dispatch_tb
`default_nettype wire
